// ---- hdl/fpmp_regs.svh ----
/*
 fpmp_regs.svh: offsets, field positions, reset values and counts for the
 flash pin mode and protect logic and its host controller.
 assumes: included by bare name from the package and both end modules.
*/
`ifndef FPMP_REGS_SVH
`define FPMP_REGS_SVH

// host register offsets (byte addresses, aligned words)
`define FPMP_OFF_CTRL 4'h0
`define FPMP_OFF_STAT 4'h4
`define FPMP_OFF_DATA 4'h8
// control register fields
`define FPMP_CTRL_HV_BIT 0
`define FPMP_CTRL_BOOTLK_BIT 1
`define FPMP_CTRL_WP_BIT 2
`define FPMP_CTRL_LOAD_BIT 3
`define FPMP_CTRL_RST_BIT 4
`define FPMP_CTRL_INIT_BIT 5
`define FPMP_CTRL_FRAME_BIT 6
`define FPMP_CTRL_DRIVE_BIT 7
// status register fields
`define FPMP_STAT_RDY_BIT 0
`define FPMP_STAT_BUSY_BIT 1
// reset value and bus response codes
`define FPMP_CTRL_RST_VAL 8'h32
`define FPMP_SLVERR 2'h2
`define FPMP_OKAY 2'h0
// programming cycle length after a load ends, in bus clocks
`define FPMP_PROG_CYCLES 8'h08
// fast-load capture buffer depth
`define FPMP_LOAD_DEPTH 4

`endif

// ---- hdl/fpmp_pkg.sv ----
/*
 fpmp_pkg.sv: types for both ends; only the device end uses any.
 assumes: fpmp_regs.svh on the include path.
*/
`include "fpmp_regs.svh"
package fpmp_pkg;
    typedef enum logic [1:0] {
        FPMP_IDLE = 2'b00,
        FPMP_LOAD = 2'b01,
        FPMP_PROG = 2'b10,
        FPMP_DONE = 2'b11
    } fpmp_load_e;

    typedef enum logic [1:0] {
        FPMP_AX_IDLE = 2'b00,
        FPMP_AX_WRESP = 2'b01,
        FPMP_AX_RRESP = 2'b10
    } fpmp_axi_e;

    typedef logic [3:0] fpmp_nib_t;
endpackage

// ---- hdl/fpmp_if.sv ----
/*
 fpmp_if.sv: pins between the flash device logic and its host.
 assumes: nibble bus and ready/busy levels are resolved here from enables.
*/
`timescale 1ns/1ns
interface fpmp_if;
    logic bus_clock;
    logic reset_n;
    logic init_n;
    logic cycle_frame_n;
    logic [3:0] nibble_host_o;
    logic [3:0] nibble_host_oe_n;
    logic [3:0] nibble_dev_o;
    logic [3:0] nibble_dev_oe_n;
    logic [3:0] nibble_bus;
    logic boot_lock_n;
    logic protect_n;
    logic fastload_hv;
    logic load_strobe_n;
    logic ready_busy_oe_n;
    logic ready_busy_out;

    // resolved wire levels
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!nibble_dev_oe_n[i]) begin
                nibble_bus[i] = nibble_dev_o[i];
            end else if (!nibble_host_oe_n[i]) begin
                nibble_bus[i] = nibble_host_o[i];
            end else begin
                nibble_bus[i] = 1'b1;
            end
        end
        ready_busy_out = ready_busy_oe_n;
    end

    modport device (
        input bus_clock, reset_n, init_n, cycle_frame_n, nibble_bus,
        input boot_lock_n, protect_n, fastload_hv, load_strobe_n,
        output nibble_dev_o, nibble_dev_oe_n, ready_busy_oe_n
    );
    modport host (
        output bus_clock, reset_n, init_n, cycle_frame_n,
        output nibble_host_o, nibble_host_oe_n,
        output boot_lock_n, protect_n, fastload_hv, load_strobe_n,
        input nibble_bus, ready_busy_out
    );
endinterface

// ---- hdl/fpmp_device.sv ----
/*
 fpmp_device.sv: pin mode and protect logic of the firmware flash.
 holds: the reset merge, the select strap match, the aux input
 register, the hardware protect decode, the mode select from the
 high-voltage pin, the fast-load load and program sequencer and
 the open-drain ready/busy enable.
 the nibble bus output enable floats at once on either reset.
 the programming length is a header count of bus clocks, not a
 real program time.
 assumes: the host drives bus_clock, frame, strobes and the mode
 pins; the interface resolves the nibble bus and the ready/busy
 wire from the enables; cycle field decoding sits outside and
 hands over the cycle strap, direction and read nibble; all
 inputs are synchronous to bus_clock.
*/
// Functional notes
// - clock taken from host bus clock
// - four-bit nibble bus carries all information
// - frame starts transfers, frame abort abandons cycle
// - both reset inputs merged identically
// - select straps match own accesses
// - straps interpreted identically in fast-load
// - aux inputs readable through register
// - host keeps aux inputs stable during read
// - aux inputs two to four ignored fast-load
// - boot-lock low protects boot block
// - boot-lock ignored in fast-load mode
// - write-protect low protects all other blocks; code ignores it in fast-load mode
// - supervoltage selects fast-load, else normal mode
// - open-drain ready/busy driven in fast-load
// - strobe low loads, high terminates
// - strobe selects buffer-free or complete flag
// - reset deselects, floats bus, aborts programming
// - load data captured on rising clock
// - boot-lock ORed with boot write-lock bit
// - host sets mode before operation
`timescale 1ns/1ns
`include "fpmp_regs.svh"
module fpmp_device (
    fpmp_if.device pins,
    input wire logic [3:0] select_strap_i,
    input wire logic [4:0] aux_inputs_i,
    input wire logic boot_wlock_bit_i,
    input wire logic [3:0] cycle_strap_i,
    input wire logic cycle_wr_i,
    input wire logic [3:0] read_nibble_i,
    input wire logic read_drive_i,
    output logic access_match_o,
    output logic fast_load_mode_o,
    output logic [4:0] aux_reg_o,
    output logic boot_protect_o,
    output logic main_protect_o,
    output logic in_cycle_o,
    output logic [3:0] load_data_o,
    output logic load_valid_o,
    output logic prog_active_o
);
    typedef struct packed {
        logic in_cycle;
        logic [4:0] aux;
        logic [3:0] load_data;
        logic load_valid;
        fpmp_pkg::fpmp_load_e ld;
        logic [7:0] prog_cnt;
        logic drive;
        logic [3:0] dout;
    } fpmp_dev_s;

    fpmp_dev_s st_q;
    fpmp_dev_s st_d;
    logic rst_n;
    logic fast;
    logic match;

    // =========================================================
    // mode and protection
    assign rst_n = pins.reset_n & pins.init_n;
    assign fast = pins.fastload_hv;

    logic [3:0] strap_eq;
    for (genvar gs = 0; gs < 4; gs++) begin : g_strap
        assign strap_eq[gs] = (select_strap_i[gs] == cycle_strap_i[gs]);
    end
    assign match = &strap_eq;
    assign access_match_o = match;
    assign fast_load_mode_o = fast;
    assign boot_protect_o = !fast &&
        (!pins.boot_lock_n || boot_wlock_bit_i);
    assign main_protect_o = !pins.protect_n && !fast;

    // =========================================================
    // aux sampling per bit; upper three frozen in fast-load
    logic [4:0] aux_next;
    for (genvar gi = 0; gi < 5; gi++) begin : g_aux
        if (gi >= 2) begin : g_gated
            assign aux_next[gi] = fast ? st_q.aux[gi] :
                aux_inputs_i[gi];
        end else begin : g_free
            assign aux_next[gi] = aux_inputs_i[gi];
        end
    end

    // =========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.load_valid = 1'b0;
        // =====================================================
        // frame and read drive
        if (!pins.cycle_frame_n) begin
            st_d.in_cycle = 1'b1;
            st_d.drive = 1'b0;
        end
        // a frame held low keeps the drivers off
        if (st_q.in_cycle && match && !cycle_wr_i &&
            pins.cycle_frame_n) begin
            st_d.drive = read_drive_i;
            st_d.dout = read_nibble_i;
        end
        // without read drive the cycle ends with frame high
        if (!read_drive_i) begin
            st_d.in_cycle = pins.cycle_frame_n ? 1'b0 : 1'b1;
        end
        // =====================================================
        // aux levels
        st_d.aux = aux_next;
        // =====================================================
        // fast-load sequencer
        if (fast) begin
            case (st_q.ld)
                fpmp_pkg::FPMP_IDLE: begin
                    if (!pins.load_strobe_n) begin
                        st_d.ld = fpmp_pkg::FPMP_LOAD;
                    end
                end
                fpmp_pkg::FPMP_LOAD: begin
                    if (!pins.load_strobe_n) begin
                        st_d.load_data = pins.nibble_bus;
                        st_d.load_valid = match;
                    end else begin
                        st_d.ld = fpmp_pkg::FPMP_PROG;
                        st_d.prog_cnt = `FPMP_PROG_CYCLES;
                    end
                end
                fpmp_pkg::FPMP_PROG: begin
                    st_d.prog_cnt = st_q.prog_cnt - 8'h01;
                    if (st_q.prog_cnt == 8'h01) begin
                        st_d.ld = fpmp_pkg::FPMP_DONE;
                    end
                end
                fpmp_pkg::FPMP_DONE: begin
                    if (!pins.load_strobe_n) begin
                        st_d.ld = fpmp_pkg::FPMP_LOAD;
                    end
                end
                default: begin
                    st_d.ld = fpmp_pkg::FPMP_IDLE;
                end
            endcase
        end else begin
            st_d.ld = fpmp_pkg::FPMP_IDLE;
        end
    end

    // =========================================================
    // state register on host clock
    // either reset pin clears all state at once
    always_ff @(posedge pins.bus_clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // pins and outputs
    always_comb begin
        pins.nibble_dev_o = st_q.dout;
        pins.nibble_dev_oe_n = {4{!(st_q.drive && rst_n)}};
        pins.ready_busy_oe_n = 1'b1;
        if (fast) begin
            if (!pins.load_strobe_n) begin
                pins.ready_busy_oe_n = 1'b0;
            end else begin
                case (st_q.ld)
                    fpmp_pkg::FPMP_LOAD: begin
                        // strobe released, programming about to start
                        pins.ready_busy_oe_n = 1'b0;
                    end
                    fpmp_pkg::FPMP_PROG: begin
                        pins.ready_busy_oe_n = 1'b0;
                    end
                    default: begin
                        pins.ready_busy_oe_n = 1'b1;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // registered outputs
    assign aux_reg_o = st_q.aux;
    assign in_cycle_o = st_q.in_cycle;
    assign load_data_o = st_q.load_data;
    assign load_valid_o = st_q.load_valid;
    assign prog_active_o = (st_q.ld == fpmp_pkg::FPMP_PROG);
endmodule

// ---- hdl/fpmp_host.sv ----
/*
 fpmp_host.sv: host side driving the flash pins from AXI4-Lite registers.
 assumes: single clock; bench joins the interface to the device end.
*/
`timescale 1ns/1ns
`include "fpmp_regs.svh"
module fpmp_host (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    fpmp_if.host pins,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] data;
        logic clk_div;
        logic aw_got;
        logic w_got;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } fpmp_host_s;

    fpmp_host_s st_q;
    fpmp_host_s st_d;

    // =========================================================
    // register bus
    always_comb begin
        st_d = st_q;
        st_d.clk_div = !st_q.clk_div;
        if (s_axi_awvalid_i && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata_i;
            st_d.wstb = s_axi_wstrb_i[0];
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.bvalid = 1'b1;
            st_d.bresp = `FPMP_OKAY;
            if (st_q.awaddr == `FPMP_OFF_CTRL) begin
                if (st_q.wstb) begin
                    st_d.ctrl = st_q.wdata[7:0];
                end
            end else if (st_q.awaddr == `FPMP_OFF_DATA) begin
                if (st_q.wstb) begin
                    st_d.data = st_q.wdata[3:0];
                end
            end else begin
                st_d.bresp = `FPMP_SLVERR;
            end
        end
        if (st_q.bvalid && s_axi_bready_i) begin
            st_d.bvalid = 1'b0;
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
        end
        if (s_axi_arvalid_i && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `FPMP_OKAY;
            case (s_axi_araddr_i)
                `FPMP_OFF_CTRL: begin
                    st_d.rdata = {24'h000000, st_q.ctrl};
                end
                `FPMP_OFF_STAT: begin
                    st_d.rdata = {30'h0, !pins.ready_busy_out,
                        pins.ready_busy_out};
                end
                `FPMP_OFF_DATA: begin
                    st_d.rdata = {28'h0000000, pins.nibble_bus};
                end
                default: begin
                    st_d.rdata = 32'h00000000;
                    st_d.rresp = `FPMP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready_i) begin
            st_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
            st_q.ctrl <= `FPMP_CTRL_RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // pins
    assign pins.bus_clock = st_q.clk_div;
    assign pins.fastload_hv = st_q.ctrl[`FPMP_CTRL_HV_BIT];
    assign pins.boot_lock_n = st_q.ctrl[`FPMP_CTRL_BOOTLK_BIT];
    assign pins.protect_n = st_q.ctrl[`FPMP_CTRL_WP_BIT];
    assign pins.load_strobe_n = !st_q.ctrl[`FPMP_CTRL_LOAD_BIT];
    // host reset also holds the flash in reset
    assign pins.reset_n = st_q.ctrl[`FPMP_CTRL_RST_BIT] && reset_n_i;
    assign pins.init_n = st_q.ctrl[`FPMP_CTRL_INIT_BIT];
    assign pins.cycle_frame_n = !st_q.ctrl[`FPMP_CTRL_FRAME_BIT];
    assign pins.nibble_host_o = st_q.data;
    assign pins.nibble_host_oe_n = {4{!st_q.ctrl[`FPMP_CTRL_DRIVE_BIT]}};
    assign s_axi_awready_o = !st_q.aw_got;
    assign s_axi_wready_o = !st_q.w_got;
    assign s_axi_bvalid_o = st_q.bvalid;
    assign s_axi_bresp_o = st_q.bresp;
    assign s_axi_arready_o = !st_q.rvalid;
    assign s_axi_rvalid_o = st_q.rvalid;
    assign s_axi_rdata_o = st_q.rdata;
    assign s_axi_rresp_o = st_q.rresp;
endmodule

// ---- bench/fpmp_props.sv ----
/*
 fpmp_props.sv: pin checks on the flash link between host and device.
 assumes: instantiated beside the interface, sampled on bus_clock.
*/
`timescale 1ns/1ns
module fpmp_props (
    input wire logic bus_clock,
    input wire logic reset_n,
    input wire logic init_n,
    input wire logic cycle_frame_n,
    input wire logic [3:0] nibble_dev_oe_n,
    input wire logic fastload_hv,
    input wire logic load_strobe_n,
    input wire logic ready_busy_oe_n
);
    default clocking cb @(posedge bus_clock); endclocking
    // ====================================
    // sequences
    sequence s_loading;
        fastload_hv && !load_strobe_n;
    endsequence
    sequence s_load_end;
        fastload_hv && $rose(load_strobe_n);
    endsequence
    sequence s_done_high;
        fastload_hv && load_strobe_n && ready_busy_oe_n;
    endsequence
    // ====================================
    // properties
    property p_rst_float;
        !reset_n |-> nibble_dev_oe_n == 4'hF;
    endproperty
    property p_init_float;
        !init_n |-> nibble_dev_oe_n == 4'hF;
    endproperty
    property p_frame_abort;
        disable iff (!(reset_n && init_n))
        !cycle_frame_n ##1 !cycle_frame_n |-> nibble_dev_oe_n == 4'hF;
    endproperty
    property p_nib_whole;
        disable iff (!(reset_n && init_n))
        nibble_dev_oe_n == 4'h0 || nibble_dev_oe_n == 4'hF;
    endproperty
    property p_normal_rel;
        disable iff (!(reset_n && init_n))
        !fastload_hv && $past(!fastload_hv) |-> ready_busy_oe_n;
    endproperty
    property p_buf_free;
        disable iff (!(reset_n && init_n))
        s_loading ##1 s_loading |-> !ready_busy_oe_n;
    endproperty
    property p_prog_busy;
        disable iff (!(reset_n && init_n))
        s_load_end |-> ##2 !ready_busy_oe_n ##[6:10] ready_busy_oe_n;
    endproperty
    property p_done_hold;
        disable iff (!(reset_n && init_n))
        s_done_high ##1 fastload_hv && load_strobe_n |-> ready_busy_oe_n;
    endproperty
    property p_exit_mode;
        disable iff (!(reset_n && init_n))
        $fell(fastload_hv) |-> ##[0:2] ready_busy_oe_n;
    endproperty
    // ====================================
    // assertions
    a_rst_float: assert property (p_rst_float)
        else $error("nibble bus driven during main reset");
    a_init_float: assert property (p_init_float)
        else $error("nibble bus driven during second reset");
    a_frame_abort: assert property (p_frame_abort)
        else $error("nibble bus driven while frame low");
    a_nib_whole: assert property (p_nib_whole)
        else $error("nibble bus partly driven");
    a_normal_rel: assert property (p_normal_rel)
        else $error("ready busy pulled in normal mode");
    a_buf_free: assert property (p_buf_free)
        else $error("buffer free flag missing while loading");
    a_prog_busy: assert property (p_prog_busy)
        else $error("programming flag timing wrong");
    a_done_hold: assert property (p_done_hold)
        else $error("complete flag dropped with strobe high");
    a_exit_mode: assert property (p_exit_mode)
        else $error("ready busy held after leaving fast load");
endmodule

// ---- bench/testbench.sv ----
/*
 testbench.sv: host and device ends joined by the pin interface.
 assumes: design files and fpmp_props.sv are compiled first.
*/
`timescale 1ns/1ns
`include "fpmp_regs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] strap = 4'h0, cstrap = 4'h0, rnib = 4'h0;
    logic [4:0] aux = 5'h00;
    logic wlock = 1'b0, rdrv = 1'b0, cwr = 1'b0;
    logic match, flm, bprot, mprot, incyc, pact, lval;
    logic [4:0] auxq, a0;
    logic [3:0] ldata;
    logic [31:0] v;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int failures = 0;
    int n_compared = 0;
    int seed = 32'h37232268;
    fpmp_if bif ();
    fpmp_host fpmp_host_i (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
        .pins(bif), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    fpmp_device fpmp_device_i (.pins(bif), .select_strap_i(strap),
        .aux_inputs_i(aux), .boot_wlock_bit_i(wlock),
        .cycle_strap_i(cstrap), .cycle_wr_i(cwr), .read_nibble_i(rnib),
        .read_drive_i(rdrv), .access_match_o(match),
        .fast_load_mode_o(flm), .aux_reg_o(auxq), .boot_protect_o(bprot),
        .main_protect_o(mprot), .in_cycle_o(incyc), .load_data_o(ldata),
        .load_valid_o(lval), .prog_active_o(pact));
    fpmp_props fpmp_props_i (.bus_clock(bif.bus_clock),
        .reset_n(bif.reset_n), .init_n(bif.init_n),
        .cycle_frame_n(bif.cycle_frame_n),
        .nibble_dev_oe_n(bif.nibble_dev_oe_n),
        .fastload_hv(bif.fastload_hv), .load_strobe_n(bif.load_strobe_n),
        .ready_busy_oe_n(bif.ready_busy_oe_n));
    // ====================================
    // clock, checks, bus tasks
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge sys_clk) begin
        if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) bready <= 1'b0;
        end while (awvalid || wvalid || bready);
    endtask
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) rready <= 1'b0;
        end while (arvalid || rready);
    endtask
    task automatic ctl(input logic [7:0] c);
        wr(`FPMP_OFF_CTRL, {24'h0, c}, `FPMP_OKAY);
    endtask
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("BAD t=%0t timeout", $time);
        print_verdict();
    end
    // ====================================
    // tests
    initial begin
        reset_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`FPMP_OFF_CTRL, {`FPMP_OKAY, 32'h32});
        wr(4'hC, 32'hFF, `FPMP_SLVERR);
        ctl(8'h3A);
        rd(`FPMP_OFF_STAT, {`FPMP_OKAY, 32'h1});
        $display("test 1 done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wlock <= v[0];
            strap <= v[7:4];
            cstrap <= v[3] ? v[7:4] : v[11:8];
            aux <= v[16:12];
            ctl({5'b00110, v[2:1], 1'b0});
            repeat (6) @(posedge sys_clk);
            chk(bprot, !v[1] || v[0]);
            chk(mprot, !v[2]);
            chk(match, strap == cstrap);
            chk(auxq, aux);
            chk(flm, 1'b0);
        end
        $display("test 2 done");
        a0 = aux;
        ctl(8'h31);
        aux <= ~a0;
        strap <= 4'h5;
        cstrap <= 4'h5;
        repeat (8) @(posedge sys_clk);
        chk(flm, 1'b1);
        chk(auxq, {a0[4:2], ~a0[1:0]});
        chk(match, 1'b1);
        chk(bprot, 1'b0);
        chk(mprot, 1'b0);
        rd(`FPMP_OFF_STAT, {`FPMP_OKAY, 32'h1});
        wr(`FPMP_OFF_DATA, 32'hA, `FPMP_OKAY);
        ctl(8'hBB);
        repeat (6) @(posedge sys_clk);
        chk(ldata, 4'hA);
        chk(lval, 1'b1);
        rd(`FPMP_OFF_STAT, {`FPMP_OKAY, 32'h2});
        ctl(8'hB3);
        rd(`FPMP_OFF_STAT, {`FPMP_OKAY, 32'h2});
        chk(pact, 1'b1);
        repeat (40) @(posedge sys_clk);
        rd(`FPMP_OFF_STAT, {`FPMP_OKAY, 32'h1});
        chk(pact, 1'b0);
        ctl(8'h32);
        $display("test 3 done");
        v = $random(seed);
        rnib <= v[3:0];
        rdrv <= 1'b1;
        ctl(8'h72);
        ctl(8'h32);
        chk(incyc, 1'b1);
        rd(`FPMP_OFF_DATA, {`FPMP_OKAY, 28'h0, rnib});
        ctl(8'h12);
        rd(`FPMP_OFF_DATA, {`FPMP_OKAY, 32'hF});
        chk(incyc, 1'b0);
        ctl(8'h72);
        ctl(8'h32);
        ctl(8'h22);
        rd(`FPMP_OFF_DATA, {`FPMP_OKAY, 32'hF});
        cstrap <= 4'h6;
        ctl(8'h72);
        ctl(8'h32);
        rd(`FPMP_OFF_DATA, {`FPMP_OKAY, 32'hF});
        cstrap <= 4'h5;
        cwr <= 1'b1;
        ctl(8'h72);
        ctl(8'h32);
        rd(`FPMP_OFF_DATA, {`FPMP_OKAY, 32'hF});
        $display("test 4 done");
        print_verdict();
    end
endmodule
